// ### dv/dsr_ctrl_model.sv
// Memory controller model that drives the DRAM clock, clock enable and command pins
`timescale 1ns/1ns
`default_nettype none

module dsr_ctrl_model (
    input  wire logic                        clk_sys,
    output logic                             link_clk,
    output logic                             clk_enable,
    output dsr_pkg::dsr_cmd_s                cmd_pins,
    output logic [dsr_pkg::DATA_W-1:0]       wr_data
);
    logic [1:0] phase;

    // Idle pins at time zero: deselected, clock enable high
    initial begin
        phase      = 2'h0;
        link_clk   = 1'b0;
        clk_enable = 1'b1;
        cmd_pins   = {1'b1, 19'h0};
        wr_data    = 8'h00;
    end

    // Link clock cycles without pause, 400 ns period, never stopped around self refresh
    always @(posedge clk_sys) begin
        phase <= phase + 2'h1;
        if (phase == 2'h3) begin
            link_clk <= ~link_clk;
        end
    end

    // One command per link cycle, changed on the falling link edge and held across the rise
    task automatic send(input dsr_pkg::dsr_cmd_s c, input logic cke, input logic [7:0] d);
        @(posedge clk_sys iff (phase == 2'h3 && link_clk));
        cmd_pins   <= c;
        clk_enable <= cke;
        wr_data    <= d;
        #1;  // Return after the edge has settled, so callers look at updated outputs
    endtask : send
endmodule : dsr_ctrl_model

`default_nettype wire

// ### dv/tb_dsr_core.sv
// Self-checking testbench for the DRAM command model
`timescale 1ns/1ns
`default_nettype none

module tb_dsr_core;
    logic                 clk_sys;
    logic                 reset;
    logic                 link_clk;
    logic                 clk_enable;
    logic                 rd_valid;
    logic                 cmd_violation;
    logic [7:0]           wr_data;
    logic [7:0]           rd_data;
    dsr_pkg::dsr_cmd_s    cmd_pins;
    dsr_pkg::dsr_status_s status;
    logic [31:0]          seed = 32'he217;
    logic [7:0]           exp_mem [0:63];
    logic [7:0]           rd_q [$];
    int                   err_count = 0;
    int                   check_count = 0;
    int                   viol_count = 0;

    dsr_core #(.READ_LINKCYC(4)) i_dsr_core (.clk_sys(clk_sys), .reset(reset), .link_clk(link_clk),
        .clk_enable(clk_enable), .cmd_pins(cmd_pins), .wr_data(wr_data), .rd_data(rd_data),
        .rd_valid(rd_valid), .cmd_violation(cmd_violation), .status(status));
    dsr_ctrl_model i_dsr_ctrl_model (.clk_sys(clk_sys), .link_clk(link_clk), .clk_enable(clk_enable),
        .cmd_pins(cmd_pins), .wr_data(wr_data));

    // System clock, 50 ns period
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // Collect read beats and refusal pulses
    always @(posedge clk_sys) begin
        if (rd_valid === 1'b1) rd_q.push_back(rd_data);
        if (cmd_violation === 1'b1) viol_count++;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // Column of beat i in a sequential burst of four
    function automatic int bcol(input int c, input int i);
        return (c & ~3) | ((c + i) & 3);
    endfunction : bcol

    function automatic dsr_pkg::dsr_cmd_s mk(input dsr_pkg::dsr_cmd_e op, input logic [1:0] b,
                                             input logic [13:0] a);
        return {1'b0, op, b, a};
    endfunction : mk

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        check_count++;
        if (seen !== want) begin
            err_count++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, want);
        end
    endtask : check

    // Idle link cycles, a random mix of no-op and deselect with random other pins
    task automatic idle(input int n, input logic cke, input logic [7:0] d = 8'h00);
        repeat (n) begin
            seed = lfsr(seed);
            i_dsr_ctrl_model.send(seed[20] ? {1'b1, seed[18:0]} : mk(dsr_pkg::DSR_CMD_NOP, seed[1:0],
                                  seed[15:2]), cke, d);
        end
    endtask : idle

    task automatic wburst(input logic [1:0] b, input int c);
        // First beat one link cycle after the command
        i_dsr_ctrl_model.send(mk(dsr_pkg::DSR_CMD_WR, b, 14'(c)), 1'b1, 8'h00);
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            exp_mem[bcol(c, i)] = seed[12:5];
            idle(1, 1'b1, seed[12:5]);
        end
    endtask : wburst

    task automatic rburst(input logic [1:0] b, input int c, input logic ap);
        rd_q.delete();
        i_dsr_ctrl_model.send(mk(dsr_pkg::DSR_CMD_RD, b, 14'(c) | {3'h0, ap, 10'h0}), 1'b1, 8'h00);
        idle(4, 1'b1);
        for (int t = 0; t < 40 && rd_q.size() < 4; t++) @(posedge clk_sys);
        check(rd_q.size(), 4);
        for (int i = 0; i < 4 && i < rd_q.size(); i++) check(rd_q[i], exp_mem[bcol(c, i)]);
    endtask : rburst

    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize

    initial begin
        int c;
        int v0;
        reset = 1'b1;
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (4) @(posedge clk_sys);
        check(status, {1'b0, 1'b1, 1'b1, 8'h00});
        i_dsr_ctrl_model.send(mk(dsr_pkg::DSR_CMD_ACT, 2'h0, 14'h0), 1'b1, 8'h00);
        idle(1, 1'b1);
        check(status.bank_open, 4'h1);
        // Write then read from a random start in the same group, first case at a group edge
        for (int k = 0; k < 5; k++) begin
            seed = lfsr(seed);
            c = (k == 0) ? 3 : int'(seed[3:0]);
            wburst(2'h0, c);
            rburst(2'h0, (c & 12) | int'(seed[9:8]), 1'b0);
        end
        // Precharge all with a closed bank on the bank pins
        i_dsr_ctrl_model.send(mk(dsr_pkg::DSR_CMD_ACT, 2'h2, 14'h5), 1'b1, 8'h00);
        idle(1, 1'b1);
        check(status.bank_open, 4'h5);
        i_dsr_ctrl_model.send(mk(dsr_pkg::DSR_CMD_PRE, 2'h1, 14'h0400), 1'b1, 8'h00);
        idle(2, 1'b1);
        check(status.bank_open, 4'h0);
        // Read with auto precharge on bank 0, long after activation
        i_dsr_ctrl_model.send(mk(dsr_pkg::DSR_CMD_ACT, 2'h0, 14'h9), 1'b1, 8'h00);
        idle(1, 1'b1);
        wburst(2'h0, 18);
        rburst(2'h0, 17, 1'b1);
        check(status.bank_open, 4'h0);
        // Self refresh entry with a bank open is refused
        v0 = viol_count;
        i_dsr_ctrl_model.send(mk(dsr_pkg::DSR_CMD_ACT, 2'h3, 14'h1), 1'b1, 8'h00);
        i_dsr_ctrl_model.send(mk(dsr_pkg::DSR_CMD_AR, 2'h0, 14'h0), 1'b0, 8'h00);
        idle(8, 1'b1);
        check(viol_count - v0, 1);
        i_dsr_ctrl_model.send(mk(dsr_pkg::DSR_CMD_PRE, 2'h0, 14'h0400), 1'b1, 8'h00);
        idle(2, 1'b1);
        // Only entry of the run, from all idle, so no re-entry follows an exit; same clock rate, no loop reset
        i_dsr_ctrl_model.send(mk(dsr_pkg::DSR_CMD_AR, 2'h0, 14'h0), 1'b0, 8'h00);
        idle(3, 1'b0);
        check(status.in_self_refresh, 1'b1);
        v0 = viol_count;
        idle(1, 1'b1);
        i_dsr_ctrl_model.send(mk(dsr_pkg::DSR_CMD_ACT, 2'h0, 14'h0), 1'b1, 8'h00);
        rd_q.delete();
        i_dsr_ctrl_model.send(mk(dsr_pkg::DSR_CMD_RD, 2'h0, 14'(c)), 1'b1, 8'h00);
        idle(6, 1'b1);
        check(viol_count - v0, 1);
        check(rd_q.size(), 0);
        check({status.in_self_refresh, status.read_allowed, status.nonread_allowed}, 3'h3);
        rburst(2'h0, c, 1'b0);
        summarize();
    end
endmodule : tb_dsr_core

`default_nettype wire

// ### logic/dsr_core.sv
// DRAM command decoder with self refresh tracking, banks and burst data path
`timescale 1ns/1ns
`default_nettype none

module dsr_core #(
    parameter int NONREAD_CYC = dsr_pkg::EXIT_NONREAD_CYC,
    parameter int READ_LINKCYC = dsr_pkg::EXIT_READ_LINKCYC
) (
    input  wire logic                         clk_sys,
    input  wire logic                         reset,
    input  wire logic                         link_clk,
    input  wire logic                         clk_enable,
    input  wire dsr_pkg::dsr_cmd_s            cmd_pins,
    input  wire logic [dsr_pkg::DATA_W-1:0]   wr_data,
    output logic [dsr_pkg::DATA_W-1:0]        rd_data,
    output logic                              rd_valid,
    output logic                              cmd_violation,
    output dsr_pkg::dsr_status_s              status
);
    // Two-stage synchronisers for all pin inputs
    logic             lclk_s1, lclk_s2, lclk_d;
    logic             cke_s1, cke_s2;
    dsr_pkg::dsr_cmd_s cmd_s1, cmd_s2;
    logic [dsr_pkg::DATA_W-1:0] wd_s1, wd_s2;
    always_ff @(posedge clk_sys) begin
        lclk_s1 <= link_clk;
        lclk_s2 <= lclk_s1;
        lclk_d  <= lclk_s2;
        cke_s1  <= clk_enable;
        cke_s2  <= cke_s1;
        cmd_s1  <= cmd_pins;
        cmd_s2  <= cmd_s1;
        wd_s1   <= wr_data;
        wd_s2   <= wd_s1;
    end

    // Command decode on each rising link clock edge
    wire logic              link_rise = lclk_s2 & ~lclk_d;
    wire dsr_pkg::dsr_cmd_e cmd_code  = cmd_s2.cs_n ? dsr_pkg::DSR_CMD_NOP
                                        : dsr_pkg::dsr_cmd_e'({cmd_s2.ras_n, cmd_s2.cas_n, cmd_s2.we_n});
    wire logic              cmd_take  = link_rise & cke_s2;
    wire logic              is_nop    = cmd_code == dsr_pkg::DSR_CMD_NOP;
    wire logic              is_rd     = cmd_code == dsr_pkg::DSR_CMD_RD;
    wire logic              is_wr     = cmd_code == dsr_pkg::DSR_CMD_WR;
    wire logic              is_act    = cmd_code == dsr_pkg::DSR_CMD_ACT;
    wire logic              is_pre    = cmd_code == dsr_pkg::DSR_CMD_PRE;
    wire logic              is_ar     = cmd_code == dsr_pkg::DSR_CMD_AR;
    wire logic              ap_high   = cmd_s2.addr[dsr_pkg::AP_BIT];
    wire logic [1:0]        bank_sel  = cmd_s2.bank;

    // Self refresh entry is an auto refresh seen on a rising link edge with enable low
    dsr_pkg::dsr_state_e  state;
    logic [dsr_pkg::CNT_W-1:0] exit_cnt, link_cnt;
    logic [dsr_pkg::NBANK-1:0] bank_open;
    wire logic sr_request = link_rise & ~cke_s2 & is_ar & state == dsr_pkg::DSR_ST_ACTIVE;
    wire logic sr_enter   = sr_request & ~|bank_open;  // Refused while any row is open
    wire logic nonread_ok = exit_cnt >= dsr_pkg::CNT_W'(NONREAD_CYC);
    wire logic read_ok    = link_cnt >= dsr_pkg::CNT_W'(READ_LINKCYC);
    wire logic in_exit    = state == dsr_pkg::DSR_ST_EXIT;
    wire logic early_cmd  = cmd_take & in_exit & ~is_nop & (is_rd ? ~read_ok : ~nonread_ok);

    // Self refresh state and exit counters
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state    <= dsr_pkg::DSR_ST_ACTIVE;
            exit_cnt <= '0;
            link_cnt <= '0;
        end else begin
            case (state)
                dsr_pkg::DSR_ST_ACTIVE: if (sr_enter) state <= dsr_pkg::DSR_ST_SELF;
                dsr_pkg::DSR_ST_SELF: begin
                    exit_cnt <= '0;
                    link_cnt <= '0;
                    if (cke_s2) state <= dsr_pkg::DSR_ST_EXIT;
                end
                dsr_pkg::DSR_ST_EXIT: begin
                    if (!nonread_ok) exit_cnt <= exit_cnt + 1'b1;
                    if (link_rise && cke_s2 && !read_ok) link_cnt <= link_cnt + 1'b1;
                    if (nonread_ok && read_ok) state <= dsr_pkg::DSR_ST_ACTIVE;
                end
                default: state <= dsr_pkg::DSR_ST_ACTIVE;
            endcase
        end
    end

    // Per-bank row timers: open flag, active-time count, auto precharge and precharge period
    logic [dsr_pkg::NBANK-1:0] ap_pend, prech;
    logic [3:0]                ras_cnt [dsr_pkg::NBANK];
    logic [3:0]                rp_cnt  [dsr_pkg::NBANK];
    logic [dsr_pkg::NBANK-1:0] pre_hit;
    always_comb begin
        for (int b = 0; b < dsr_pkg::NBANK; b++) begin
            pre_hit[b] = cmd_take & is_pre & (ap_high | bank_sel == 2'(b));
        end
    end
    wire logic [dsr_pkg::NBANK-1:0] ras_met_v;
    for (genvar g = 0; g < dsr_pkg::NBANK; g++) begin : g_ras
        assign ras_met_v[g] = ras_cnt[g] >= 4'(dsr_pkg::RAS_MIN_CYC);
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            bank_open <= '0;
            ap_pend   <= '0;
            prech     <= '0;
            for (int b = 0; b < dsr_pkg::NBANK; b++) begin
                ras_cnt[b] <= '0;
                rp_cnt[b]  <= '0;
            end
        end else begin
            for (int b = 0; b < dsr_pkg::NBANK; b++) begin
                if (cmd_take && is_act && bank_sel == 2'(b)) begin
                    bank_open[b] <= 1'b1;
                    ras_cnt[b]   <= '0;
                end else if (bank_open[b] && !ras_met_v[b]) begin
                    ras_cnt[b] <= ras_cnt[b] + 1'b1;
                end
                // Internal precharge waits for the active-time minimum
                if ((ap_pend[b] && ras_met_v[b]) || pre_hit[b]) begin
                    ap_pend[b]   <= 1'b0;
                    bank_open[b] <= 1'b0;
                    prech[b]     <= bank_open[b];
                    rp_cnt[b]    <= '0;
                end else if (prech[b]) begin
                    rp_cnt[b] <= rp_cnt[b] + 1'b1;
                    if (rp_cnt[b] + 1'b1 >= 4'(dsr_pkg::RP_CYC)) prech[b] <= 1'b0;
                end
                // A new auto precharge request wins over a clear in the same cycle
                if (cmd_take && (is_rd || is_wr) && ap_high && bank_sel == 2'(b)) ap_pend[b] <= 1'b1;
            end
        end
    end

    // Burst engine: column sequence wraps inside the burst, sequential order
    logic [dsr_pkg::DATA_W-1:0] mem [dsr_pkg::MEM_DEPTH];
    logic [dsr_pkg::MEM_AW-1:0] base_col;
    logic [1:0]                 beat;
    logic [2:0]                 left;
    logic                       burst_wr;
    wire logic [dsr_pkg::MEM_AW-1:0] cur_col = {base_col[dsr_pkg::MEM_AW-1:2],
                                               base_col[1:0] + beat & dsr_pkg::BL_MASK};
    wire logic start_burst = cmd_take & (is_rd | is_wr) & ~early_cmd & state != dsr_pkg::DSR_ST_SELF;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            base_col <= '0;
            beat     <= '0;
            left     <= '0;
            burst_wr <= 1'b0;
            rd_valid <= 1'b0;
            rd_data  <= '0;
        end else begin
            rd_valid <= 1'b0;
            if (start_burst) begin
                base_col <= cmd_s2.addr[dsr_pkg::MEM_AW-1:0];
                beat     <= '0;
                left     <= dsr_pkg::BL_DEFAULT;
                burst_wr <= is_wr;
            end else if (left != 3'h0 && link_rise) begin
                if (burst_wr) mem[cur_col] <= wd_s2;
                else begin
                    rd_data  <= mem[cur_col];
                    rd_valid <= 1'b1;
                end
                beat <= beat + 1'b1;
                left <= left - 1'b1;
            end
        end
    end

    // Violation flag and status outputs, all registered
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cmd_violation <= 1'b0;
            status        <= '0;
        end else begin
            cmd_violation <= early_cmd | (sr_request & |bank_open);
            status        <= '{in_self_refresh: state == dsr_pkg::DSR_ST_SELF,
                               read_allowed: state == dsr_pkg::DSR_ST_ACTIVE | (in_exit & read_ok),
                               nonread_allowed: state == dsr_pkg::DSR_ST_ACTIVE | (in_exit & nonread_ok),
                               bank_open: bank_open, bank_precharging: prech};
        end
    end

    // Checks
    AST_PRE_ALL_CLOSES: assert property (@(posedge clk_sys) disable iff (reset)
        cmd_take && is_pre && ap_high |=> bank_open == '0) else $error("precharge all left a bank open");
    AST_NOP_NO_BURST: assert property (@(posedge clk_sys) disable iff (reset)
        cmd_take && is_nop |=> $stable(left) || left == $past(left) - 3'h1) else $error("nop started a burst");
    AST_AP_WAITS_RAS: assert property (@(posedge clk_sys) disable iff (reset)
        $fell(bank_open[0]) && $past(ap_pend[0]) |-> $past(ras_met_v[0])) else $error("auto precharge too early");
    AST_RP_LENGTH: assert property (@(posedge clk_sys) disable iff (reset)
        $rose(prech[0]) |-> prech[0][*1] ##1 !prech[0]) else $error("precharge period wrong");
    AST_BANK_IGNORED: assert property (@(posedge clk_sys) disable iff (reset)
        cmd_take && is_pre && ap_high && bank_sel != 2'h0 && !(cmd_take && is_act) |=> !bank_open[0])
        else $error("bank address not ignored");
    AST_EXIT_NONREAD: assert property (@(posedge clk_sys) disable iff (reset)
        $rose(in_exit) |-> !nonread_ok [*3]) else $error("nonread delay too short");
    AST_READ_GATED: assert property (@(posedge clk_sys) disable iff (reset)
        in_exit && !read_ok && cmd_take && is_rd |=> cmd_violation) else $error("early read not flagged");
    AST_BURST_COL: assert property (@(posedge clk_sys) disable iff (reset)
        start_burst |=> cur_col == $past(cmd_s2.addr[dsr_pkg::MEM_AW-1:0])) else $error("burst start column");
    AST_WR_STORE: assert property (@(posedge clk_sys) disable iff (reset)
        burst_wr && left != 3'h0 && link_rise && !start_burst |=> mem[$past(cur_col)] == $past(wd_s2))
        else $error("write beat not stored");
    COV_SELF_REFRESH: cover property (@(posedge clk_sys) sr_enter);
    COV_EXIT_DONE: cover property (@(posedge clk_sys) $fell(in_exit));
    COV_READ_BURST: cover property (@(posedge clk_sys) rd_valid [*1] ##1 1'b1);
    COV_AUTO_PRE: cover property (@(posedge clk_sys) $fell(ap_pend[0]));
endmodule : dsr_core

`default_nettype wire

// ### logic/dsr_pkg.sv
// Package with command codes, timing constants and bundles for the DRAM command model
package dsr_pkg;
    localparam int CLK_PERIOD_NS      = 50;
    localparam int T_NONREAD_PS       = 127500;  // Self refresh exit to non-read command
    localparam int EXIT_NONREAD_CYC   = (T_NONREAD_PS + CLK_PERIOD_NS * 1000 - 1) / (CLK_PERIOD_NS * 1000);
    localparam int EXIT_READ_LINKCYC  = 200;     // Link clock cycles with enable high before a read
    localparam int T_RAS_MIN_NS       = 40;
    localparam int RAS_MIN_CYC        = (T_RAS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_RP_NS            = 20;
    localparam int RP_CYC             = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int NBANK              = 4;
    localparam int AP_BIT             = 10;      // Auto precharge address bit
    localparam int ROW_W              = 14;
    localparam int COL_W              = 10;
    localparam int DATA_W             = 8;
    localparam int MEM_DEPTH          = 64;      // Small model array per device
    localparam int MEM_AW             = 6;
    localparam int CNT_W              = 9;
    localparam logic [2:0] BL_DEFAULT = 3'h4;
    localparam logic [1:0] BL_MASK    = 2'h3;

    // Decoded command, ras/cas/we encoding
    typedef enum logic [2:0] {
        DSR_CMD_LMR  = 3'b000,
        DSR_CMD_AR   = 3'b001,
        DSR_CMD_PRE  = 3'b010,
        DSR_CMD_ACT  = 3'b011,
        DSR_CMD_WR   = 3'b100,
        DSR_CMD_RD   = 3'b101,
        DSR_CMD_BST  = 3'b110,
        DSR_CMD_NOP  = 3'b111
    } dsr_cmd_e;

    typedef enum logic [1:0] {
        DSR_ST_ACTIVE = 2'b00,
        DSR_ST_SELF   = 2'b01,
        DSR_ST_EXIT   = 2'b10
    } dsr_state_e;

    // Command pins as one bundle
    typedef struct packed {
        logic              cs_n;
        logic              ras_n;
        logic              cas_n;
        logic              we_n;
        logic [1:0]        bank;
        logic [ROW_W-1:0]  addr;
    } dsr_cmd_s;

    // Status seen by the outside world
    typedef struct packed {
        logic              in_self_refresh;
        logic              read_allowed;
        logic              nonread_allowed;
        logic [NBANK-1:0]  bank_open;
        logic [NBANK-1:0]  bank_precharging;
    } dsr_status_s;
endpackage : dsr_pkg
